/* File: rtl/ssc_pkg.sv */
package ssc_pkg;

  // geometry
  localparam int NUM_SPACES = 4;
  localparam int SPACE_W    = 2;
  localparam int APB_AW     = 12;
  localparam int MEM_AW     = 20;
  localparam int DATA_W     = 32;

  // register byte offsets, one aligned word each
  localparam logic [APB_AW-1:0] OFF_SEC0   = 12'h000;
  localparam logic [APB_AW-1:0] OFF_TYPE0  = 12'h010;
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h020;

  // secondary control fields
  localparam int SEC_W         = 7;
  localparam int SEC_CLK_BIT   = 6;
  localparam int SEC_RMODE_BIT = 5;
  localparam int SEC_EXT_BIT   = 4;
  localparam int SEC_WL_LSB    = 2;
  localparam int SEC_RL_LSB    = 0;
  localparam logic [SEC_W-1:0] SEC_RESET = 7'h02;

  // memory type field of the primary register
  localparam int TYPE_LSB = 4;
  localparam int TYPE_W   = 4;
  localparam logic [TYPE_W-1:0] TYPE_RESET  = 4'h0;
  localparam logic [TYPE_W-1:0] MT_SYNC32   = 4'h4;
  localparam logic [TYPE_W-1:0] MT_SYNC8    = 4'hA;
  localparam logic [TYPE_W-1:0] MT_SYNC16   = 4'hB;
  localparam logic [TYPE_W-1:0] MT_SYNC64   = 4'hE;

  // status fields
  localparam int STAT_BUSY_BIT = 0;

  // link sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_DESEL = 4'b1000
  } ssc_link_st_t;

  function automatic logic ssc_is_sync(input logic [TYPE_W-1:0] t);
    return (t == MT_SYNC32) || (t == MT_SYNC8) || (t == MT_SYNC16) || (t == MT_SYNC64);
  endfunction

endpackage

/* File: rtl/ssc_sync.sv */
`timescale 1ns/1ps
module ssc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: rtl/ssc_top.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ssc_top
  import ssc_pkg::*;
(
  // apb clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [APB_AW-1:0]    paddr,
  input  wire logic [DATA_W-1:0]    pwdata,
  output logic      [DATA_W-1:0]    prdata,
  output logic                      pready,
  output logic                      pslverr,
  // transfer controller commands
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic                 cmd_write,
  input  wire logic [SPACE_W-1:0]   cmd_space,
  input  wire logic [MEM_AW-1:0]    cmd_addr,
  input  wire logic [DATA_W-1:0]    cmd_wdata,
  input  wire logic                 cmd_pending,
  output logic                      rsp_valid,
  output logic                      rsp_error,
  output logic      [DATA_W-1:0]    rsp_rdata,
  // memory link
  input  wire logic                 link_clk,
  output logic      [NUM_SPACES-1:0] mem_ce_n,
  output logic                      mem_strobe_n,
  output logic                      mem_we_n,
  output logic                      mem_oe_n,
  output logic      [MEM_AW-1:0]    mem_addr,
  output logic      [DATA_W-1:0]    mem_dq_o,
  output logic                      mem_dq_oe,
  input  wire logic [DATA_W-1:0]    mem_dq_i,
  output logic                      sync_clock_select
);

  // ---------------- pclk domain ----------------
  logic [SEC_W-1:0]   sec_q [NUM_SPACES];
  logic [TYPE_W-1:0]  type_q [NUM_SPACES];
  logic [DATA_W-1:0]  prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               busy_q;
  logic               cmd_ready_q;
  logic               rsp_valid_q;
  logic               rsp_error_q;
  logic [DATA_W-1:0]  rsp_rdata_q;
  logic               req_tgl_q;
  logic               ack_prev_q;
  logic               ack_s;
  logic               l_wr_q;
  logic [SPACE_W-1:0] l_space_q;
  logic [MEM_AW-1:0]  l_addr_q;
  logic [DATA_W-1:0]  l_wdata_q;
  logic [SEC_W-1:0]   l_cfg_q;
  logic               pend_q;

  // link domain state, declared early for the crossing
  logic [DATA_W-1:0]  link_rdata_q;
  logic               ack_tgl_q;

  wire [SPACE_W-1:0] ridx     = paddr[3:2];
  wire               aligned  = (paddr[1:0] == 2'h0);
  wire               hit_sec  = aligned && (paddr[APB_AW-1:4] == OFF_SEC0[APB_AW-1:4]);
  wire               hit_type = aligned && (paddr[APB_AW-1:4] == OFF_TYPE0[APB_AW-1:4]);
  wire               hit_stat = (paddr == OFF_STATUS);
  wire               mapped   = hit_sec | hit_type | hit_stat;
  wire               setup    = psel & ~penable;
  wire               acc      = psel & penable & pready_q;
  wire               wr_en    = acc & pwrite & mapped;

  wire [DATA_W-1:0] rd_word =
    hit_sec  ? {25'h0000000, sec_q[ridx]} :
    hit_type ? {24'h000000, type_q[ridx], 4'h0} :
    hit_stat ? {31'h00000000, busy_q} :
    32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= setup ? rd_word : prdata_q;
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  for (genvar g = 0; g < NUM_SPACES; g++) begin : g_space
    wire idx_hit = (ridx == SPACE_W'(g));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sec_q[g]  <= SEC_RESET;
        type_q[g] <= TYPE_RESET;
      end else begin
        // only the low seven bits are stored
        if (wr_en && hit_sec && idx_hit) begin
          sec_q[g] <= pwdata[SEC_W-1:0];
        end
        if (wr_en && hit_type && idx_hit) begin
          type_q[g] <= pwdata[TYPE_LSB +: TYPE_W];
        end
      end
    end
  end

  // memory type decides whether a command may run
  wire accept     = cmd_valid & cmd_ready_q;
  wire space_sync = ssc_is_sync(type_q[cmd_space]);
  wire launch     = accept & space_sync;
  // other memory types get an error answer, no memory cycle
  wire reject     = accept & ~space_sync;
  wire ack_evt    = ack_s ^ ack_prev_q;
  wire busy_d     = launch | (busy_q & ~ack_evt);

  // ack toggle returns from the link clock
  ssc_sync #(.W(1)) u_ack_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ack_tgl_q),
    .q     (ack_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q      <= 1'b0;
      cmd_ready_q <= 1'b0;
      req_tgl_q   <= 1'b0;
      ack_prev_q  <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_rdata_q <= 32'h00000000;
      pend_q      <= 1'b0;
    end else begin
      busy_q      <= busy_d;
      cmd_ready_q <= ~busy_d;
      req_tgl_q   <= req_tgl_q ^ launch;
      ack_prev_q  <= ack_s;
      rsp_valid_q <= ack_evt | reject;
      rsp_error_q <= reject;
      rsp_rdata_q <= ack_evt ? link_rdata_q : rsp_rdata_q;
      pend_q      <= cmd_pending;
    end
  end

  // command words stay put until the link acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l_wr_q    <= 1'b0;
      l_space_q <= '0;
      l_addr_q  <= '0;
      l_wdata_q <= 32'h00000000;
      l_cfg_q   <= SEC_RESET;
    end else if (launch) begin
      l_wr_q    <= cmd_write;
      l_space_q <= cmd_space;
      l_addr_q  <= cmd_addr;
      l_wdata_q <= cmd_wdata;
      l_cfg_q   <= sec_q[cmd_space];
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign cmd_ready = cmd_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_error = rsp_error_q;
  assign rsp_rdata = rsp_rdata_q;

  // secondary reads never show upper bits
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_sec) |=> (prdata_q[DATA_W-1:SEC_W] == 25'h0000000))
    else $error("reserved secondary bits read nonzero");

  // a non synchronous space never starts a cycle
  reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    reject |=> (rsp_valid_q && rsp_error_q && $stable(req_tgl_q)))
    else $error("rejected command reached the link");

  // a synchronous type launches a cycle
  launch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && ssc_is_sync(type_q[cmd_space])) |=> (!cmd_ready_q && $changed(req_tgl_q)))
    else $error("synchronous space did not launch");

  // ---------------- link domain ----------------
  logic               lrst_n;
  logic               req_s;
  logic               pend_s;
  logic               req_prev_q;
  ssc_link_st_t       st_q;
  ssc_link_st_t       st_d;
  logic [1:0]         cnt_q;
  logic [NUM_SPACES-1:0] ce_n_q;
  logic               strobe_n_q;
  logic               we_n_q;
  logic               oe_n_q;
  logic [MEM_AW-1:0]  addr_q;
  logic [DATA_W-1:0]  dq_o_q;
  logic               dq_oe_q;
  logic               clk_sel_q;

  // reset release is retimed onto the link clock
  ssc_sync #(.W(1)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (lrst_n)
  );

  ssc_sync #(.W(2)) u_req_sync (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({pend_q, req_tgl_q}),
    .q     ({pend_s, req_s})
  );

  wire       rd      = ~l_wr_q;
  wire       rmode   = l_cfg_q[SEC_RMODE_BIT];
  wire       ext     = l_cfg_q[SEC_EXT_BIT];
  wire       clk_sel = l_cfg_q[SEC_CLK_BIT];
  wire [1:0] wl      = l_cfg_q[SEC_WL_LSB +: 2];
  wire [1:0] rl      = l_cfg_q[SEC_RL_LSB +: 2];
  wire [1:0] lat     = rd ? rl : wl;
  wire       take    = (req_s ^ req_prev_q) && (st_q == ST_IDLE);
  wire       active  = (st_q == ST_CMD) || (st_q == ST_WAIT);
  wire       last    = active && (cnt_q == lat);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  st_d = take ? ST_CMD : ST_IDLE;
      ST_CMD, ST_WAIT: begin
        // deselect only with nothing pending, never in read mode
        if (last) begin
          st_d = (!rmode && !pend_s) ? ST_DESEL : ST_IDLE;
        end else begin
          st_d = ST_WAIT;
        end
      end
      ST_DESEL: st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  wire [1:0] cnt_d = take ? 2'h0 : ((active && !last) ? cnt_q + 2'h1 : cnt_q);

  // pins are decoded for the cycle being entered
  wire cmd_n  = (st_d == ST_CMD);
  wire act_n  = (st_d == ST_CMD) || (st_d == ST_WAIT);
  wire hit_n  = (cnt_d == lat);
  // output enable and capture sit N edges after the command
  wire oe_on  = act_n && rd && hit_n;
  // chip enable for the command cycle only, plus the output enable window when ext is set
  wire ce_on  = cmd_n || (ext && oe_on);
  // address strobe on every command, read enable only on reads
  wire stb_on = (cmd_n && (!rmode || rd)) || (st_d == ST_DESEL);
  wire we_on  = cmd_n && !rd;
  // write data appears N cycles after the command
  wire dq_on  = act_n && !rd && hit_n;
  wire [NUM_SPACES-1:0] ce_vec = ~({{(NUM_SPACES-1){1'b0}}, 1'b1} << l_space_q);

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      st_q       <= ST_IDLE;
      cnt_q      <= 2'h0;
      req_prev_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      req_prev_q <= take ? req_s : req_prev_q;
      ack_tgl_q  <= ack_tgl_q ^ last;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ce_n_q       <= {NUM_SPACES{1'b1}};
      strobe_n_q   <= 1'b1;
      we_n_q       <= 1'b1;
      oe_n_q       <= 1'b1;
      addr_q       <= '0;
      dq_o_q       <= 32'h00000000;
      dq_oe_q      <= 1'b0;
      clk_sel_q    <= 1'b0;
      link_rdata_q <= 32'h00000000;
    end else begin
      ce_n_q       <= ce_on ? ce_vec : {NUM_SPACES{1'b1}};
      strobe_n_q   <= ~stb_on;
      we_n_q       <= ~we_on;
      oe_n_q       <= ~oe_on;
      addr_q       <= cmd_n ? l_addr_q : addr_q;
      dq_o_q       <= dq_on ? l_wdata_q : dq_o_q;
      dq_oe_q      <= dq_on;
      // clock select follows the space in use
      clk_sel_q    <= act_n ? clk_sel : clk_sel_q;
      // read capture on the latency edge
      link_rdata_q <= (last && rd) ? mem_dq_i : link_rdata_q;
    end
  end

  assign mem_ce_n          = ce_n_q;
  assign mem_strobe_n      = strobe_n_q;
  assign mem_we_n          = we_n_q;
  assign mem_oe_n          = oe_n_q;
  assign mem_addr          = addr_q;
  assign mem_dq_o          = dq_o_q;
  assign mem_dq_oe         = dq_oe_q;
  assign sync_clock_select = clk_sel_q;

  // a selected space shows its own clock choice
  clk_select_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (!(&ce_n_q)) |-> (clk_sel_q == clk_sel))
    else $error("clock select does not match space");

  // writes strobe in address strobe mode
  ads_write_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (!we_n_q && !rmode) |-> (!strobe_n_q && !(&ce_n_q)))
    else $error("write command without address strobe");

  deselect_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ST_DESEL) |-> (!strobe_n_q && (&ce_n_q) && !$past(pend_s) && !rmode))
    else $error("bad deselect cycle");

  // read enable strobe only for read commands
  read_strobe_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (!strobe_n_q && rmode) |-> (st_q == ST_CMD && rd))
    else $error("read enable strobe outside a read");

  // no chip enable after the command without extension
  ce_drop_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ST_WAIT && !ext) |-> (&ce_n_q))
    else $error("chip enable held without extension");

  // extended chip enable covers output enable
  ce_extend_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (!oe_n_q && ext) |-> !(&ce_n_q))
    else $error("chip enable missing during output enable");

  // write data lands at the write latency
  wr_latency_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (!we_n_q) |-> ((wl == 2'h0 && dq_oe_q) or (wl == 2'h1 ##1 dq_oe_q)
                   or (wl == 2'h2 ##2 dq_oe_q) or (wl == 2'h3 ##3 dq_oe_q)))
    else $error("write data latency wrong");

  // output enable lands at the read latency
  rd_latency_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ST_CMD && rd) |-> ((rl == 2'h0 && !oe_n_q) or (rl == 2'h1 ##1 !oe_n_q)
                   or (rl == 2'h2 ##2 !oe_n_q) or (rl == 2'h3 ##3 !oe_n_q)))
    else $error("read data latency wrong");

endmodule

/* File: verification/ssc_mem_model.sv */
`timescale 1ns/1ps
module ssc_mem_model
  import ssc_pkg::*;
(
  // link clock and reset
  input  wire logic                  link_clk,
  input  wire logic                  presetn,
  // memory pins
  input  wire logic [NUM_SPACES-1:0] mem_ce_n,
  input  wire logic                  mem_strobe_n,
  input  wire logic                  mem_we_n,
  input  wire logic                  mem_oe_n,
  input  wire logic [MEM_AW-1:0]     mem_addr,
  input  wire logic [DATA_W-1:0]     mem_dq_o,
  input  wire logic                  mem_dq_oe,
  output logic      [DATA_W-1:0]     mem_dq_i,
  // observations
  output logic      [7:0]            desel_cnt,
  output logic      [7:0]            strobe_cnt,
  output logic      [7:0]            ce_cnt,
  output logic      [7:0]            noce_cnt,
  output logic      [7:0]            lat_rd,
  output logic      [7:0]            lat_wr
);
  logic      [DATA_W-1:0] mem_q [16];
  logic      [7:0]        cyc_q;
  logic      [7:0]        cmd_cyc_q;
  wire logic              sel_w  = (mem_ce_n != {NUM_SPACES{1'h1}});
  wire logic              cmd_w  = sel_w && (!mem_strobe_n || !mem_we_n);
  wire logic [7:0]        base_w = cmd_w ? cyc_q : cmd_cyc_q;

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 32'hC0DE_0000 + 32'(i);
    end
  end

  // idle bus flips every cycle so a stale word is never taken for data
  assign mem_dq_i = !mem_oe_n ? mem_q[mem_addr[3:0]] : {16{cyc_q[0], ~cyc_q[0]}};

  always @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      cyc_q      <= 8'h0;
      cmd_cyc_q  <= 8'h0;
      desel_cnt  <= 8'h0;
      strobe_cnt <= 8'h0;
      ce_cnt     <= 8'h0;
      noce_cnt   <= 8'h0;
      lat_rd     <= 8'h0;
      lat_wr     <= 8'h0;
    end else begin
      cyc_q <= cyc_q + 8'h1;
      if (cmd_w) cmd_cyc_q <= cyc_q;
      if (!mem_strobe_n) strobe_cnt <= strobe_cnt + 8'h1;
      if (!mem_strobe_n && !sel_w) desel_cnt <= desel_cnt + 8'h1;
      if (sel_w) ce_cnt <= ce_cnt + 8'h1;
      if (!mem_oe_n && !sel_w) noce_cnt <= noce_cnt + 8'h1;
      if (!mem_oe_n) lat_rd <= cyc_q - base_w;
      if (mem_dq_oe) begin
        lat_wr <= cyc_q - base_w;
        mem_q[mem_addr[3:0]] <= mem_dq_o;
      end
    end
  end
endmodule

/* File: verification/ssc_top_tb.sv */
`timescale 1ns/1ps
module ssc_top_tb
  import ssc_pkg::*;
();
  logic                  pclk, presetn, link_clk, psel, penable, pwrite;
  logic [APB_AW-1:0]     paddr;
  logic [DATA_W-1:0]     pwdata, prdata, rsp_rdata, cmd_wdata, mem_dq_o, mem_dq_i, r_data;
  logic                  pready, pslverr, cmd_valid, cmd_ready, cmd_write, cmd_pending;
  logic                  rsp_valid, rsp_error, mem_strobe_n, mem_we_n, mem_oe_n, mem_dq_oe;
  logic                  sync_clock_select, r_err;
  logic [SPACE_W-1:0]    cmd_space;
  logic [MEM_AW-1:0]     cmd_addr, mem_addr;
  logic [NUM_SPACES-1:0] mem_ce_n;
  logic [7:0]            desel_cnt, strobe_cnt, ce_cnt, noce_cnt, lat_rd, lat_wr;
  logic [7:0]            d_desel, d_strobe, d_ce, d_noce;
  int                    mismatches, comparisons;

  ssc_top ssc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmd_valid, .cmd_ready, .cmd_write, .cmd_space, .cmd_addr, .cmd_wdata,
    .cmd_pending, .rsp_valid, .rsp_error, .rsp_rdata, .link_clk, .mem_ce_n, .mem_strobe_n,
    .mem_we_n, .mem_oe_n, .mem_addr, .mem_dq_o, .mem_dq_oe, .mem_dq_i, .sync_clock_select);
  ssc_mem_model ssc_mem_model_i (.link_clk, .presetn, .mem_ce_n, .mem_strobe_n, .mem_we_n,
    .mem_oe_n, .mem_addr, .mem_dq_o, .mem_dq_oe, .mem_dq_i, .desel_cnt, .strobe_cnt,
    .ce_cnt, .noce_cnt, .lat_rd, .lat_wr);

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // link clock phase is unrelated to pclk
  initial begin
    link_clk = 1'h0;
    #3.7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'h0, 1'h1);
    finish_test();
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) hang();
    r_data = prdata;
    r_err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // one command, waits for its response, leaves link activity counts in d_*
  task automatic cmd(input logic wr, input logic [1:0] sp, input logic [MEM_AW-1:0] a,
                     input logic [31:0] wd, input logic pend);
    int         n;
    logic [7:0] s0, s1, s2, s3;
    s0 = desel_cnt;
    s1 = strobe_cnt;
    s2 = ce_cnt;
    s3 = noce_cnt;
    @(posedge pclk);
    cmd_valid   <= 1'h1;
    cmd_write   <= wr;
    cmd_space   <= sp;
    cmd_addr    <= a;
    cmd_wdata   <= wd;
    cmd_pending <= pend;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (cmd_ready === 1'h1) break;
    end
    if (n == 50) hang();
    cmd_valid <= 1'h0;
    for (n = 0; n < 300; n++) begin
      @(posedge pclk);
      if (rsp_valid === 1'h1) break;
    end
    if (n == 300) hang();
    r_data   = rsp_rdata;
    r_err    = rsp_error;
    // the trailing deselect cycle lands after the response crosses back
    repeat (3) @(posedge link_clk);
    d_desel  = desel_cnt - s0;
    d_strobe = strobe_cnt - s1;
    d_ce     = ce_cnt - s2;
    d_noce   = noce_cnt - s3;
  endtask

  task automatic t_regs();
    for (int i = 0; i < NUM_SPACES; i++) begin
      apb(1'h0, OFF_SEC0 + 12'(4 * i), 32'h0);
      chk32(r_data, 32'h0000_0002);
      apb(1'h0, OFF_TYPE0 + 12'(4 * i), 32'h0);
      chk32(r_data, 32'h0);
    end
    apb(1'h1, OFF_SEC0 + 12'h4, 32'hFFFF_FFFF);
    apb(1'h0, OFF_SEC0 + 12'h4, 32'h0);
    chk32(r_data, 32'h0000_007F);
    chk1(r_err, 1'h0);
    apb(1'h0, OFF_SEC0, 32'h0);
    chk32(r_data, 32'h0000_0002);
    apb(1'h0, 12'h030, 32'h0);
    chk1(r_err, 1'h1);
  endtask

  // non-synchronous codes are refused with no link activity
  task automatic t_types();
    logic [3:0] codes [6] = '{4'h0, 4'h3, 4'h4, 4'hA, 4'hB, 4'hE};
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, OFF_TYPE0, {24'h0, codes[i], 4'h0});
      cmd(1'h0, 2'h0, 20'h8, 32'h0, 1'h0);
      chk1(r_err, 1'(i < 2));
      chk32({24'h0, d_ce}, (i < 2) ? 32'h0 : 32'h1);
      if (i >= 2) chk32(r_data, 32'hC0DE_0008);
    end
  endtask

  task automatic t_write();
    apb(1'h1, OFF_TYPE0 + 12'h4, 32'h40);
    for (int wl = 0; wl < 4; wl++) begin
      apb(1'h1, OFF_SEC0 + 12'h4, {28'h0, 2'(wl), 2'h0});
      cmd(1'h1, 2'h1, 20'(wl), 32'h5A5A_0000 + 32'(wl), 1'h0);
      chk1(r_err, 1'h0);
      chk32({24'h0, lat_wr}, 32'(wl));
      chk32({24'h0, d_desel}, 32'h1);
      chk32({24'h0, d_strobe}, 32'h2);
    end
  endtask

  task automatic t_read();
    for (int rl = 0; rl < 4; rl++) begin
      apb(1'h1, OFF_SEC0 + 12'h4, 32'(rl));
      cmd(1'h0, 2'h1, 20'(rl), 32'h0, 1'h0);
      chk32(r_data, 32'h5A5A_0000 + 32'(rl));
      chk32({24'h0, lat_rd}, 32'(rl));
      chk32({24'h0, d_ce}, 32'h1);
      chk32({24'h0, d_noce}, (rl == 0) ? 32'h0 : 32'h1);
      chk32({24'h0, d_desel}, 32'h1);
    end
    cmd(1'h0, 2'h1, 20'h0, 32'h0, 1'h1);
    chk32({24'h0, d_desel}, 32'h0);
    chk32({24'h0, d_strobe}, 32'h1);
  endtask

  task automatic t_rmode();
    apb(1'h1, OFF_SEC0 + 12'h4, 32'h21);
    cmd(1'h1, 2'h1, 20'h4, 32'h0BAD_F00D, 1'h0);
    chk32({24'h0, d_strobe}, 32'h0);
    chk32({24'h0, d_desel}, 32'h0);
    cmd(1'h0, 2'h1, 20'h4, 32'h0, 1'h0);
    chk32(r_data, 32'h0BAD_F00D);
    chk32({24'h0, d_strobe}, 32'h1);
    chk32({24'h0, d_desel}, 32'h0);
  endtask

  task automatic t_ext();
    apb(1'h1, OFF_SEC0 + 12'h4, 32'h12);
    cmd(1'h0, 2'h1, 20'h1, 32'h0, 1'h0);
    chk32(r_data, 32'h5A5A_0001);
    chk32({24'h0, lat_rd}, 32'h2);
    chk32({24'h0, d_ce}, 32'h2);
    chk32({24'h0, d_noce}, 32'h0);
  endtask

  task automatic t_clk();
    apb(1'h1, OFF_TYPE0 + 12'h8, 32'h40);
    apb(1'h1, OFF_SEC0 + 12'h8, 32'h42);
    cmd(1'h0, 2'h2, 20'h2, 32'h0, 1'h0);
    chk1(sync_clock_select, 1'h1);
    cmd(1'h0, 2'h1, 20'h2, 32'h0, 1'h0);
    chk1(sync_clock_select, 1'h0);
  endtask

  initial begin
    presetn     = 1'h0;
    psel        = 1'h0;
    penable     = 1'h0;
    pwrite      = 1'h0;
    paddr       = '0;
    pwdata      = '0;
    cmd_valid   = 1'h0;
    cmd_write   = 1'h0;
    cmd_space   = '0;
    cmd_addr    = '0;
    cmd_wdata   = '0;
    cmd_pending = 1'h0;
    mismatches  = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    repeat (12) @(posedge pclk);
    t_regs();
    t_types();
    t_write();
    t_read();
    t_rmode();
    t_ext();
    t_clk();
    finish_test();
  end
endmodule
